// >>> fsp_cfg.svh
// constants for flash sector protection block
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_NSECT        16
`define FSP_SECT_W       4
`define FSP_ADDR_CTRL    12'h000
`define FSP_ADDR_CMD     12'h004
`define FSP_ADDR_RESULT  12'h008
`define FSP_ADDR_STATUS  12'h00c
`define FSP_ADDR_PBITS   12'h010
`define FSP_ADDR_DBITS   12'h014
`define FSP_CMD_OP_LSB   0
`define FSP_CMD_SECT_LSB 8
`define FSP_CMD_WP_BIT   16
`define FSP_PBIT_RST     16'hffff
`define FSP_DBIT_RST     16'h0000
`define FSP_FREEZE_RST   1'b1
`define FSP_ERASE_NS     50
`define FSP_ERASE_CYC    ((`FSP_ERASE_NS + 9) / 10)
`endif

// >>> fsp_pkg.sv
// types for flash sector protection block
`default_nettype none
package fsp_pkg;
    typedef enum logic [3:0] {
        FSP_OP_NONE, FSP_OP_PROG, FSP_OP_ERASE, FSP_OP_PBIT_PROG,
        FSP_OP_PBIT_ERASE_ALL, FSP_OP_FREEZE_SET, FSP_OP_DYN_SET,
        FSP_OP_DYN_CLEAR, FSP_OP_SCHEME_PERS, FSP_OP_SCHEME_PASS,
        FSP_OP_SCHEME_BOTH, FSP_OP_LOCK_REG
    } fsp_op_t;
    typedef enum logic [1:0] {
        FSP_RES_NONE, FSP_RES_GRANTED, FSP_RES_REFUSED, FSP_RES_ABORTED
    } fsp_res_t;
endpackage : fsp_pkg
`default_nettype wire

// >>> fsp_cmd_if.sv
// command carrier between decoder and protection core
`timescale 1ns/1ps
`default_nettype none
interface fsp_cmd_if;
    import fsp_pkg::*;
    logic            valid;
    fsp_pkg::fsp_op_t op;
    logic [3:0]      sector;
    logic            wp_n;
    modport src (output valid, output op, output sector, output wp_n);
    modport dst (input valid, input op, input sector, input wp_n);
endinterface : fsp_cmd_if
`default_nettype wire

// >>> fsp_apb_cmd.sv
// apb write to command register turns into one command pulse
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_apb_cmd
    import fsp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_cmd,
    input  wire logic [31:0] wdata,
    input  wire logic        wp_n_pin,
    fsp_cmd_if.src           cmd
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd.valid  <= 1'b0;
            cmd.op     <= FSP_OP_NONE;
            cmd.sector <= 4'h0;
            cmd.wp_n   <= 1'b1;
        end else begin
            cmd.valid <= wr_cmd;
            if (wr_cmd) begin
                cmd.op     <= fsp_op_t'(wdata[`FSP_CMD_OP_LSB +: 4]);
                cmd.sector <= wdata[`FSP_CMD_SECT_LSB +: 4];
                // wp sampled on the final write of the sequence
                cmd.wp_n   <= wp_n_pin & wdata[`FSP_CMD_WP_BIT];
            end
        end
    end
endmodule : fsp_apb_cmd
`default_nettype wire

// >>> fsp_apb_slv.sv
// apb register decode for the protection block
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_apb_slv (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             wr_cmd,
    output logic             acc_phase,
    output logic             known_addr
);
    always_comb begin
        acc_phase  = psel & penable;
        known_addr = (paddr == `FSP_ADDR_CTRL)   ||
                     (paddr == `FSP_ADDR_CMD)    ||
                     (paddr == `FSP_ADDR_RESULT) ||
                     (paddr == `FSP_ADDR_STATUS) ||
                     (paddr == `FSP_ADDR_PBITS)  ||
                     (paddr == `FSP_ADDR_DBITS);
        wr_cmd     = acc_phase & pwrite & (paddr == `FSP_ADDR_CMD);
    end
endmodule : fsp_apb_slv
`default_nettype wire

// >>> fsp_top.sv
// flash sector protection core with apb access
// Notes on behaviour
// - persistent method is in force until a scheme bit is set
// - once a scheme bit is set the method never changes again
// - setting both scheme bits together aborts, neither changes
// - delivered state: all persistent bits erased, sectors still protected by dynamic bits
// - write-protect pin guards the top sectors regardless of scheme
// - one persistent bit per sector, each programmed on its own
// - erase-all clears every persistent bit in one internal run
// - persistent bits survive reset; only program or erase-all changes
// - freeze bit 0 locks persistent bits, 1 lets them change; an erase-all run already under way still completes and erases them
// - freeze bit returns to 1 only through reset
// - freeze-set command writes 0; persistent changes then refused
// - one dynamic bit per sector, all 0 after reset
// - dynamic set writes 0, clear writes 1, freeze ignored
// - protected when persistent or dynamic bit is 0
// - programming the lock register restores dynamic defaults
// - program or erase on a protected sector is refused
// - dynamic, persistent and freeze bits readable as status
// - wp sampled on the last command write; low blocks top two
// - acceleration pin low locks every sector
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_top
    import fsp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wp_n_pin,
    input  wire logic        high_voltage_speedup_pin_n,
    output logic             op_start,
    output logic [3:0]       op_sector,
    output logic             op_erase,
    output logic             read_mode
);
    logic                wr_cmd;
    logic                acc_phase;
    logic                known_addr;
    logic [15:0]         persistent_protect_bit;
    logic [15:0]         dynamic_protect_bit;
    logic                persistent_bits_freeze;
    logic                scheme_pers;
    logic                scheme_pass;
    logic                nv_loaded;
    logic [15:0]         nv_pbits = `FSP_PBIT_RST;
    logic                nv_pers  = 1'b0;
    logic                nv_pass  = 1'b0;
    logic [2:0]          erase_cnt;
    logic                erase_busy;
    fsp_res_t            result;
    logic [3:0]          last_sector;
    logic                prot_now;
    fsp_cmd_if           cmd ();

    fsp_apb_slv u_slv (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .wr_cmd     (wr_cmd),
        .acc_phase  (acc_phase),
        .known_addr (known_addr)
    );

    fsp_apb_cmd u_cmd (
        .pclk     (pclk),
        .presetn  (presetn),
        // command lands at the edge that completes the access
        .wr_cmd   (wr_cmd & pready),
        .wdata    (pwdata),
        .wp_n_pin (wp_n_pin),
        .cmd      (cmd)
    );

    function automatic logic sect_protected(input logic [3:0] s,
                                            input logic [15:0] pb,
                                            input logic [15:0] db,
                                            input logic wpn,
                                            input logic accn);
        logic top;
        top = (s >= 4'(`FSP_NSECT - 2));
        // freeze bit deliberately not part of this decision
        sect_protected = !pb[s] || !db[s] ||
                         (top && !wpn) ||
                         !accn;
    endfunction

    always_comb begin
        prot_now = sect_protected(cmd.sector, persistent_protect_bit,
                                  dynamic_protect_bit, cmd.wp_n,
                                  high_voltage_speedup_pin_n);
    end

    // nonvolatile cells: no reset, so contents ride through presetn
    // power-up image (delivered state) comes from the declarations
    always_ff @(posedge pclk) begin
        if (cmd.valid && persistent_bits_freeze && !erase_busy) begin
            case (cmd.op)
                FSP_OP_PBIT_PROG:
                    nv_pbits[cmd.sector] <= 1'b0;
                default: ;
            endcase
        end
        if (erase_busy && erase_cnt == 3'd1)
            nv_pbits <= `FSP_PBIT_RST;
        if (cmd.valid && !scheme_pers && !scheme_pass) begin
            case (cmd.op)
                FSP_OP_SCHEME_PERS: nv_pers <= 1'b1;
                FSP_OP_SCHEME_PASS: nv_pass <= 1'b1;
                default: ;
            endcase
        end
    end

    always_comb begin
        persistent_protect_bit = nv_pbits;
        scheme_pers            = nv_pers;
        scheme_pass            = nv_pass;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_loaded <= 1'b0;
        end else begin
            nv_loaded <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            persistent_bits_freeze <= `FSP_FREEZE_RST;
        end else if (cmd.valid && cmd.op == FSP_OP_FREEZE_SET) begin
            persistent_bits_freeze <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dynamic_protect_bit <= `FSP_DBIT_RST;
        end else if (cmd.valid) begin
            case (cmd.op)
                FSP_OP_DYN_SET:
                    dynamic_protect_bit[cmd.sector] <= 1'b0;
                FSP_OP_DYN_CLEAR:
                    dynamic_protect_bit[cmd.sector] <= 1'b1;
                FSP_OP_LOCK_REG:
                    dynamic_protect_bit <= `FSP_DBIT_RST;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_busy <= 1'b0;
            erase_cnt  <= 3'd0;
        end else if (erase_busy) begin
            erase_cnt <= erase_cnt - 3'd1;
            if (erase_cnt == 3'd1)
                erase_busy <= 1'b0;
        end else if (cmd.valid && cmd.op == FSP_OP_PBIT_ERASE_ALL &&
                     persistent_bits_freeze) begin
            // preprogram and verify run internally, host just waits
            // limitation: a freeze set mid-run does not stop this run
            erase_busy <= 1'b1;
            erase_cnt  <= 3'(`FSP_ERASE_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_start  <= 1'b0;
            op_sector <= 4'h0;
            op_erase  <= 1'b0;
        end else begin
            op_start <= cmd.valid && !prot_now &&
                        (cmd.op == FSP_OP_PROG ||
                         cmd.op == FSP_OP_ERASE);
            if (cmd.valid) begin
                op_sector <= cmd.sector;
                op_erase  <= (cmd.op == FSP_OP_ERASE);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result      <= FSP_RES_NONE;
            last_sector <= 4'h0;
            read_mode   <= 1'b1;
        end else begin
            read_mode <= !erase_busy;
            if (cmd.valid) begin
                last_sector <= cmd.sector;
                case (cmd.op)
                    FSP_OP_PROG, FSP_OP_ERASE:
                        result <= prot_now ? FSP_RES_REFUSED
                                           : FSP_RES_GRANTED;
                    FSP_OP_PBIT_PROG, FSP_OP_PBIT_ERASE_ALL:
                        result <= (persistent_bits_freeze && !erase_busy)
                                  ? FSP_RES_GRANTED
                                  : FSP_RES_REFUSED;
                    FSP_OP_SCHEME_BOTH:
                        result <= FSP_RES_ABORTED;
                    FSP_OP_SCHEME_PERS, FSP_OP_SCHEME_PASS:
                        result <= (scheme_pers || scheme_pass)
                                  ? FSP_RES_REFUSED
                                  : FSP_RES_GRANTED;
                    default:
                        result <= FSP_RES_GRANTED;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (acc_phase && !pready) begin
            pready  <= 1'b1;
            pslverr <= !known_addr;
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `FSP_ADDR_CTRL:
                        // method field: 0 means persistent (default)
                        prdata <= {30'h0, scheme_pass, scheme_pers};
                    `FSP_ADDR_RESULT:
                        prdata <= {26'h0, last_sector, result};
                    `FSP_ADDR_STATUS:
                        prdata <= {28'h0, nv_loaded, read_mode,
                                   erase_busy,
                                   persistent_bits_freeze};
                    `FSP_ADDR_PBITS:
                        prdata <= {16'h0, persistent_protect_bit};
                    `FSP_ADDR_DBITS:
                        prdata <= {16'h0, dynamic_protect_bit};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    property p_freeze_locks;
        @(posedge pclk) disable iff (!presetn)
        (!persistent_bits_freeze) |=> $stable(persistent_protect_bit);
    endproperty
    a_freeze_locks: assert property (p_freeze_locks)
        else $error("persistent bits changed while frozen");

    property p_freeze_sticky;
        @(posedge pclk) disable iff (!presetn)
        !persistent_bits_freeze |=> !persistent_bits_freeze;
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky)
        else $error("freeze bit cleared without reset");

    property p_freeze_set;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && cmd.op == FSP_OP_FREEZE_SET
            |=> !persistent_bits_freeze;
    endproperty
    a_freeze_set: assert property (p_freeze_set)
        else $error("freeze set command had no effect");

    property p_dyn_set;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && cmd.op == FSP_OP_DYN_SET
            |=> !dynamic_protect_bit[$past(cmd.sector)];
    endproperty
    a_dyn_set: assert property (p_dyn_set)
        else $error("dynamic set did not write 0");

    property p_dyn_clear;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && cmd.op == FSP_OP_DYN_CLEAR
            |=> dynamic_protect_bit[$past(cmd.sector)];
    endproperty
    a_dyn_clear: assert property (p_dyn_clear)
        else $error("dynamic clear did not write 1");

    property p_prot_refuse;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && prot_now && cmd.op == FSP_OP_PROG
            |=> !op_start && result == FSP_RES_REFUSED;
    endproperty
    a_prot_refuse: assert property (p_prot_refuse)
        else $error("protected sector operation started");

    property p_acc_lock;
        @(posedge pclk) disable iff (!presetn)
        !high_voltage_speedup_pin_n && cmd.valid |=> !op_start;
    endproperty
    a_acc_lock: assert property (p_acc_lock)
        else $error("operation started with acceleration pin low");

    property p_scheme_both;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && cmd.op == FSP_OP_SCHEME_BOTH
            |=> $stable(scheme_pers) && $stable(scheme_pass);
    endproperty
    a_scheme_both: assert property (p_scheme_both)
        else $error("scheme bits changed on double select");

    property p_scheme_fixed;
        @(posedge pclk) disable iff (!presetn)
        scheme_pers || scheme_pass |=> $stable({scheme_pers, scheme_pass});
    endproperty
    a_scheme_fixed: assert property (p_scheme_fixed)
        else $error("protection method switched");

    property p_erase_all;
        @(posedge pclk) disable iff (!presetn)
        $rose(erase_busy) |-> ##[1:8] (persistent_protect_bit == 16'hffff);
    endproperty
    a_erase_all: assert property (p_erase_all)
        else $error("erase-all did not clear persistent bits");

    // busy window is the erase-all cycle count
    property p_erase_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(erase_busy) |-> erase_busy [*5] ##1 !erase_busy;
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase-all busy window has wrong length");

    property p_wp_top;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && !cmd.wp_n && cmd.sector >= 4'(`FSP_NSECT - 2)
            |=> !op_start;
    endproperty
    a_wp_top: assert property (p_wp_top)
        else $error("top sector operation started with wp low");

    property p_op_grant;
        @(posedge pclk) disable iff (!presetn)
        cmd.valid && !prot_now &&
            (cmd.op == FSP_OP_PROG || cmd.op == FSP_OP_ERASE)
            |=> op_start && op_sector == $past(cmd.sector);
    endproperty
    a_op_grant: assert property (p_op_grant)
        else $error("granted operation did not start");
endmodule : fsp_top
`default_nettype wire

// >>> fsp_host.sv
// apb host model that issues protection commands to the block
`timescale 1ns/1ps
`default_nettype none
module fsp_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic             wp_n
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        wp_n    = 1'b0;
    end

    // held until pready is seen at an edge; the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask

    // level sampled with the final command write
    task automatic pin(input logic v);
        @(posedge pclk);
        wp_n <= v;
    endtask
endmodule // fsp_host
`default_nettype wire

// >>> flash_sector_protection_test.sv
// self-checking bench for the flash sector protection block
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module flash_sector_protection_test
    import fsp_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wp_n;
    logic        accel_n;
    logic        op_start;
    logic [3:0]  op_sector;
    logic        op_erase;
    logic        read_mode;
    int          error_cnt;
    int          cmp_count;
    int          op_cnt;
    int          cyc;
    integer      seed;
    logic [32:0] exp_q[$];
    logic [3:0]  exp_sec;
    logic        exp_er;
    logic [15:0] exp_d;
    logic [3:0]  s;

    fsp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wp_n_pin(wp_n),
        .high_voltage_speedup_pin_n(accel_n), .op_start(op_start),
        .op_sector(op_sector), .op_erase(op_erase),
        .read_mode(read_mode));

    fsp_host u_host (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .wp_n(wp_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string n, input logic [32:0] seen,
                         input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // result monitor: oldest note is judged when read data appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0)
                check("unexpected read", 33'h0, 33'h1);
            else
                check("read word", {pslverr, prdata}, exp_q.pop_front());
        end
        if (op_start === 1'b1) begin
            op_cnt++;
            check("op_sector", {29'h0, op_sector}, 33'(exp_sec));
            check("op_erase", {32'h0, op_erase}, 33'(exp_er));
        end
    end

    // run ceiling well above the few hundred cycles the tests take
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    function automatic logic [31:0] cmdw(input fsp_op_t op,
                                         input logic [3:0] sec);
        return {15'h0, 1'b1, 4'h0, sec, 4'h0, op};
    endfunction

    task automatic cmd(input fsp_op_t op, input logic [3:0] sec);
        u_host.xfer(1'b1, `FSP_ADDR_CMD, cmdw(op, sec));
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 32'h0);
    endtask

    task automatic res(input logic [3:0] sec, input fsp_res_t r);
        rd(`FSP_ADDR_RESULT, {27'h0, sec, r});
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic done(input string n);
        repeat (3) @(posedge pclk);
        $display("test %s done", n);
    endtask

    initial begin
        presetn = 1'b0;
        accel_n = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        cyc = 0;
        seed = 32'h9d09;
        exp_sec = 4'h0;
        exp_d = 16'h0000;
        exp_er = 1'b0;
        op_cnt = 0;
        do_reset();
        u_host.pin(1'b0);
        rd(`FSP_ADDR_CTRL, 33'h0);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_ffff);
        rd(`FSP_ADDR_DBITS, 33'h0);
        rd(`FSP_ADDR_STATUS, 33'h0_0000_000d);
        rd(12'h020, 33'h1_0000_0000);
        done("reset state");
        cmd(FSP_OP_PROG, 4'h3);
        res(4'h3, FSP_RES_REFUSED);
        cmd(FSP_OP_DYN_CLEAR, 4'h3);
        rd(`FSP_ADDR_DBITS, 33'h0_0000_0008);
        exp_sec = 4'h3;
        cmd(FSP_OP_PROG, 4'h3);
        res(4'h3, FSP_RES_GRANTED);
        cmd(FSP_OP_PBIT_PROG, 4'h3);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_fff7);
        cmd(FSP_OP_ERASE, 4'h3);
        res(4'h3, FSP_RES_REFUSED);
        done("dynamic and persistent");
        cmd(FSP_OP_PBIT_ERASE_ALL, 4'h0);
        rd(`FSP_ADDR_STATUS, 33'h0_0000_000b);
        check("read_mode", {32'h0, read_mode}, 33'h0);
        repeat (8) @(posedge pclk);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_ffff);
        done("erase all");
        cmd(FSP_OP_DYN_CLEAR, 4'hf);
        cmd(FSP_OP_PROG, 4'hf);
        res(4'hf, FSP_RES_REFUSED);
        u_host.pin(1'b1);
        exp_sec = 4'hf;
        exp_er = 1'b1;
        cmd(FSP_OP_ERASE, 4'hf);
        res(4'hf, FSP_RES_GRANTED);
        accel_n <= 1'b0;
        cmd(FSP_OP_PROG, 4'h3);
        res(4'h3, FSP_RES_REFUSED);
        accel_n <= 1'b1;
        done("pins");
        cmd(FSP_OP_FREEZE_SET, 4'h0);
        rd(`FSP_ADDR_STATUS, 33'h0_0000_000c);
        cmd(FSP_OP_PBIT_PROG, 4'h5);
        res(4'h5, FSP_RES_REFUSED);
        cmd(FSP_OP_PBIT_ERASE_ALL, 4'h0);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_ffff);
        exp_d = 16'h8008;
        for (int i = 0; i < 4; i++) begin
            s = 4'($random(seed));
            exp_d[s] = 1'b1;
            cmd(FSP_OP_DYN_CLEAR, s);
        end
        rd(`FSP_ADDR_DBITS, {17'h0, exp_d});
        cmd(FSP_OP_DYN_SET, 4'h3);
        exp_d[3] = 1'b0;
        rd(`FSP_ADDR_DBITS, {17'h0, exp_d});
        done("freeze");
        cmd(FSP_OP_SCHEME_BOTH, 4'h0);
        res(4'h0, FSP_RES_ABORTED);
        rd(`FSP_ADDR_CTRL, 33'h0);
        cmd(FSP_OP_SCHEME_PERS, 4'h0);
        rd(`FSP_ADDR_CTRL, 33'h1);
        cmd(FSP_OP_SCHEME_PASS, 4'h0);
        rd(`FSP_ADDR_CTRL, 33'h1);
        cmd(FSP_OP_LOCK_REG, 4'h0);
        rd(`FSP_ADDR_DBITS, 33'h0);
        done("scheme and lock register");
        cmd(FSP_OP_DYN_CLEAR, 4'h2);
        cmd(FSP_OP_PBIT_PROG, 4'h0);
        do_reset();
        rd(`FSP_ADDR_STATUS, 33'h0_0000_000d);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_ffff);
        rd(`FSP_ADDR_DBITS, 33'h0);
        rd(`FSP_ADDR_CTRL, 33'h1);
        cmd(FSP_OP_PBIT_PROG, 4'h0);
        rd(`FSP_ADDR_PBITS, 33'h0_0000_fffe);
        do_reset();
        rd(`FSP_ADDR_PBITS, 33'h0_0000_fffe);
        check("op starts", 33'(op_cnt), 33'h2);
        done("second reset");
        results();
    end
endmodule // flash_sector_protection_test
`default_nettype wire
